// ---- isodio_pkg.sv ----
// shared constants and types for the isolated digital i/o block
package isodio_pkg;

	localparam int NUM_IN  = 8;
	localparam int NUM_OUT = 7;

	// register byte offsets (low address byte)
	localparam logic [7:0] OFS_POLARITY = 8'h00;
	localparam logic [7:0] OFS_OUTPUT   = 8'h04;
	localparam logic [7:0] OFS_RAW_IN   = 8'h08;
	localparam logic [7:0] OFS_LATCH    = 8'h0c;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
	localparam logic [7:0] OFS_IRQ_EN   = 8'h14;
	localparam logic [7:0] OFS_IRQ_CLR  = 8'h18;
	localparam logic [7:0] OFS_CMD_PORT = 8'h20;
	localparam logic [7:0] OFS_DATA_PORT = 8'h24;

	// values after reset
	localparam logic [7:0]  POLARITY_RST = 8'h00;
	localparam logic [6:0]  OUTPUT_RST   = 7'h00;
	localparam logic [7:0]  LATCH_RST    = 8'h00;
	localparam logic [7:0]  IRQ_EN_RST   = 8'h00;
	localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;

	// status word bit positions
	localparam int ST_CMD_READY  = 0;
	localparam int ST_DATA_READY = 1;
	localparam int ST_DATA_EMPTY = 2;
	localparam int ST_CONV_BUSY  = 3;

	// queue depth
	localparam int QUEUE_DEPTH = 4;

	// ahb-lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic       HRESP_OKAY    = 1'h0;

	typedef enum logic [1:0] {
		BUS_IDLE   = 2'b01,
		BUS_RDWAIT = 2'b10
	} isodio_bus_e;

	function automatic logic [31:0] isodio_zext8(input logic [7:0] v);
		return {24'h00_0000, v};
	endfunction : isodio_zext8

endpackage : isodio_pkg

// ---- isodio_queue.sv ----
// small show-ahead queue with registered head, flags and flush
`timescale 1ns/1ps
module isodio_queue
	import isodio_pkg::*;
#(
	parameter int WIDTH = 32,
	parameter int DEPTH = QUEUE_DEPTH
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             flush,
	input  wire logic             push,
	input  wire logic [WIDTH-1:0] din,
	input  wire logic             pop,
	output logic      [WIDTH-1:0] head,
	output logic                  valid,
	output logic                  full
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_reg;
	logic [AW-1:0]    rd_reg;
	logic [AW-1:0]    rd_next;
	logic [AW:0]      cnt_reg;
	logic [AW:0]      cnt_next;
	logic             do_push;
	logic             do_pop;

	// a full queue drops the push; the full output warns the writer
	assign do_push = push && (cnt_reg != CNT_FULL);
	assign do_pop  = pop && (cnt_reg != '0);
	assign rd_next = do_pop ? rd_reg + AW'(1) : rd_reg;

	always_comb begin
		cnt_next = cnt_reg;
		if (do_push && !do_pop) begin
			cnt_next = cnt_reg + (AW+1)'(1);
		end else if (do_pop && !do_push) begin
			cnt_next = cnt_reg - (AW+1)'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (do_push) begin
			mem[wr_reg] <= din;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || flush) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
			valid   <= 1'b0;
			full    <= 1'b0;
			head    <= '0;
		end else begin
			if (do_push) begin
				wr_reg <= wr_reg + AW'(1);
			end
			rd_reg  <= rd_next;
			cnt_reg <= cnt_next;
			valid   <= (cnt_next != '0);
			full    <= (cnt_next == CNT_FULL);
			// bypass when the slot being written becomes the head
			head    <= (do_push && wr_reg == rd_next) ? din : mem[rd_next];
		end
	end

endmodule : isodio_queue

// ---- isodio_top.sv ----
// isolated digital i/o with latched inputs, open-collector outputs and queues
//
// Overview of operation
// - eight-bit polarity setting per input; 0 active high, 1 active low
// - polarity setting reads back exactly as written
// - bits 0 to 6 of written value switch the seven outputs, 1 means on
// - output state reads back as last written
// - raw input read gives present input levels, polarity not applied
// - eight-bit latched input state honours each channel's polarity
// - latch clear mask: bit 0 clears that channel, bit 1 keeps it
// - status: command ready bit0, data ready bit1, data empty bit2, busy bit3
// - data port read pops next data entry; write empties both queues
`timescale 1ns/1ps
module isodio_top
	import isodio_pkg::*;
(
	input  wire logic        SYS_CLK,
	input  wire logic        SYS_RST,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	input  wire logic [7:0]  ISO_IN,
	output logic      [6:0]  OC_OUT,
	output logic             IRQ,
	output logic             CMD_VALID,
	output logic      [31:0] CMD_DATA,
	input  wire logic        CMD_TAKE,
	input  wire logic        DQ_PUSH,
	input  wire logic [31:0] DQ_DATA,
	output logic             DQ_FULL,
	input  wire logic        CONV_BUSY
);

	////////////////////////////////////////////////////////////////////////
	// bus phase tracking

	isodio_bus_e bus_reg;
	logic        addr_ok;
	logic        wr_pend_reg;
	logic [7:0]  wr_ofs_reg;
	logic [7:0]  rd_ofs_reg;

	logic [7:0]  polarity_reg;
	logic [6:0]  output_reg;
	logic [7:0]  latch_reg;
	logic [7:0]  latch_next;
	logic [7:0]  irq_stat_reg;
	logic [7:0]  irq_en_reg;
	logic [7:0]  active_lvl;
	logic [7:0]  clr_keep;
	logic [7:0]  irq_clr;
	logic [3:0]  status_word;
	logic [31:0] rd_mux;
	logic [31:0] dq_head;
	logic        dq_valid;
	logic        cmd_full;
	logic        wr_fire;
	logic        rd_fire;
	logic        cmd_push;
	logic        dq_pop;
	logic        q_flush;

	// size is not checked: every access is treated as a whole word
	assign addr_ok = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);
	assign wr_fire = wr_pend_reg;
	assign rd_fire = (bus_reg == BUS_RDWAIT);

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			bus_reg     <= BUS_IDLE;
			wr_pend_reg <= 1'b0;
			wr_ofs_reg  <= 8'h00;
			rd_ofs_reg  <= 8'h00;
		end else begin
			wr_pend_reg <= addr_ok && HWRITE;
			if (addr_ok) begin
				wr_ofs_reg <= HADDR[7:0];
				rd_ofs_reg <= HADDR[7:0];
			end
			unique case (bus_reg)
				BUS_IDLE: begin
					if (addr_ok && !HWRITE) begin
						bus_reg <= BUS_RDWAIT;
					end
				end
				BUS_RDWAIT: begin
					bus_reg <= BUS_IDLE;
				end
			endcase
		end
	end

	// reads take one wait state so a write just before is already visible
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			HREADYOUT <= 1'b1;
			HRDATA    <= WORD_ZERO;
			HRESP     <= HRESP_OKAY;
		end else begin
			HRESP <= HRESP_OKAY;
			if (bus_reg == BUS_IDLE && addr_ok && !HWRITE) begin
				HREADYOUT <= 1'b0;
			end else begin
				HREADYOUT <= 1'b1;
			end
			if (rd_fire) begin
				HRDATA <= rd_mux;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read decode

	assign status_word[ST_CMD_READY]  = !cmd_full;
	assign status_word[ST_DATA_READY] = dq_valid;
	assign status_word[ST_DATA_EMPTY] = !dq_valid;
	assign status_word[ST_CONV_BUSY]  = CONV_BUSY;

	always_comb begin
		unique case (rd_ofs_reg)
			OFS_POLARITY:  rd_mux = isodio_zext8(polarity_reg);
			OFS_OUTPUT:    rd_mux = isodio_zext8({1'b0, output_reg});
			OFS_RAW_IN:    rd_mux = isodio_zext8(ISO_IN);
			OFS_LATCH:     rd_mux = isodio_zext8(latch_reg);
			OFS_IRQ_STAT:  rd_mux = isodio_zext8(irq_stat_reg);
			OFS_IRQ_EN:    rd_mux = isodio_zext8(irq_en_reg);
			OFS_CMD_PORT:  rd_mux = {28'h000_0000, status_word};
			OFS_DATA_PORT: rd_mux = dq_valid ? dq_head : WORD_ZERO;
			default:       rd_mux = WORD_ZERO;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// configuration and output registers

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			polarity_reg <= POLARITY_RST;
		end else if (wr_fire && wr_ofs_reg == OFS_POLARITY) begin
			polarity_reg <= HWDATA[7:0];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			output_reg <= OUTPUT_RST;
		end else if (wr_fire && wr_ofs_reg == OFS_OUTPUT) begin
			output_reg <= HWDATA[6:0];
		end
	end

	// field drivers: a 1 turns the open-collector transistor on
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			OC_OUT <= OUTPUT_RST;
		end else if (wr_fire && wr_ofs_reg == OFS_OUTPUT) begin
			OC_OUT <= HWDATA[6:0];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			irq_en_reg <= IRQ_EN_RST;
		end else if (wr_fire && wr_ofs_reg == OFS_IRQ_EN) begin
			irq_en_reg <= HWDATA[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// input latch

	// xor maps an active-low channel's low level to active
	assign active_lvl = ISO_IN ^ polarity_reg;
	assign clr_keep   = (wr_fire && wr_ofs_reg == OFS_LATCH) ? HWDATA[7:0] : 8'hff;
	// a channel still active wins over its own clear
	assign latch_next = (latch_reg & clr_keep) | active_lvl;

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			latch_reg <= LATCH_RST;
		end else begin
			latch_reg <= latch_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupts: a latch bit going from clear to set is the event

	assign irq_clr = (wr_fire && wr_ofs_reg == OFS_IRQ_CLR) ? HWDATA[7:0] : 8'h00;

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			irq_stat_reg <= LATCH_RST;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | (latch_next & ~latch_reg);
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |(((irq_stat_reg & ~irq_clr) | (latch_next & ~latch_reg)) & irq_en_reg);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// command and data queues

	assign cmd_push = wr_fire && wr_ofs_reg == OFS_CMD_PORT;
	assign q_flush  = wr_fire && wr_ofs_reg == OFS_DATA_PORT;
	assign dq_pop   = rd_fire && rd_ofs_reg == OFS_DATA_PORT;

	isodio_queue #(
		.WIDTH (32),
		.DEPTH (QUEUE_DEPTH)
	) u_cmd_q (
		.clk   (SYS_CLK),
		.rst   (SYS_RST),
		.flush (q_flush),
		.push  (cmd_push),
		.din   (HWDATA),
		.pop   (CMD_TAKE),
		.head  (CMD_DATA),
		.valid (CMD_VALID),
		.full  (cmd_full)
	);

	isodio_queue #(
		.WIDTH (32),
		.DEPTH (QUEUE_DEPTH)
	) u_data_q (
		.clk   (SYS_CLK),
		.rst   (SYS_RST),
		.flush (q_flush),
		.push  (DQ_PUSH),
		.din   (DQ_DATA),
		.pop   (dq_pop),
		.head  (dq_head),
		.valid (dq_valid),
		.full  (DQ_FULL)
	);

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SYS_RST);

	sequence pol_write_s;
		wr_fire && wr_ofs_reg == OFS_POLARITY;
	endsequence

	sequence rd_of_s(logic [7:0] ofs);
		rd_fire && rd_ofs_reg == ofs;
	endsequence

	polarity_store_a: assert property (
		pol_write_s |=> polarity_reg == $past(HWDATA[7:0]))
		else $error("polarity setting not stored");

	polarity_read_a: assert property (
		rd_of_s(OFS_POLARITY) |=> HRDATA == {24'h00_0000, $past(polarity_reg)} && HREADYOUT)
		else $error("polarity readback wrong");

	output_drive_a: assert property (
		wr_fire && wr_ofs_reg == OFS_OUTPUT |=> OC_OUT == $past(HWDATA[6:0]))
		else $error("outputs not driven from written value");

	output_read_a: assert property (
		rd_of_s(OFS_OUTPUT) |=> HRDATA == {25'h000_0000, OC_OUT})
		else $error("output readback wrong");

	raw_input_a: assert property (
		rd_of_s(OFS_RAW_IN) |=> HRDATA[7:0] == $past(ISO_IN))
		else $error("raw input read applied polarity");

	latch_set_a: assert property (
		(ISO_IN ^ polarity_reg) != 8'h00
			|=> (latch_reg & ($past(ISO_IN) ^ $past(polarity_reg)))
			== ($past(ISO_IN) ^ $past(polarity_reg)))
		else $error("active channel not latched");

	latch_clear_a: assert property (
		wr_fire && wr_ofs_reg == OFS_LATCH && (ISO_IN ^ polarity_reg) == 8'h00
			|=> latch_reg == ($past(latch_reg) & $past(HWDATA[7:0])))
		else $error("latch clear mask misapplied");

	status_word_a: assert property (
		rd_of_s(OFS_CMD_PORT) |=> HRDATA[3:0] == {$past(CONV_BUSY), !$past(dq_valid),
			$past(dq_valid), !$past(cmd_full)})
		else $error("status word bits wrong");

	flush_both_a: assert property (
		q_flush |=> !CMD_VALID && !dq_valid ##1 !dq_valid || $past(DQ_PUSH))
		else $error("data port write did not empty queues");

	latch_hold_a: assert property (
		latch_reg[0] && !(wr_fire && wr_ofs_reg == OFS_LATCH) |=> latch_reg[0])
		else $error("latch bit dropped without clear");

	sequence rd_wait_s;
		!HREADYOUT ##1 HREADYOUT;
	endsequence

	// one wait state per read, none per write
	read_wait_a: assert property (
		addr_ok && !HWRITE |=> rd_wait_s)
		else $error("read wait state wrong");

	write_nowait_a: assert property (
		addr_ok && HWRITE |=> HREADYOUT)
		else $error("write stalled the bus");

	empty_read_a: assert property (
		rd_fire && rd_ofs_reg == OFS_DATA_PORT && !dq_valid |=> HRDATA == WORD_ZERO)
		else $error("empty data port read not zero");

	cmd_push_a: assert property (
		cmd_push && !cmd_full |=> CMD_VALID)
		else $error("command not queued");

	oc_mirror_a: assert property (
		OC_OUT == output_reg)
		else $error("output readback differs from pins");

	irq_level_a: assert property (
		1'b1 |=> IRQ == |(irq_stat_reg & $past(irq_en_reg)))
		else $error("interrupt level wrong");

	irq_clear_a: assert property (
		wr_fire && wr_ofs_reg == OFS_IRQ_CLR && (latch_next & ~latch_reg) == 8'h00
			|=> (irq_stat_reg & $past(HWDATA[7:0])) == 8'h00)
		else $error("interrupt status not cleared");

endmodule : isodio_top

// ---- isodio_ctrl_model.sv ----
// embedded controller model: drains commands, answers into the data queue
`timescale 1ns/1ps
module isodio_ctrl_model
	import isodio_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        hold,
	input  wire logic        cmd_valid,
	input  wire logic [31:0] cmd_data,
	output logic             cmd_take,
	output logic             dq_push,
	output logic      [31:0] dq_data,
	output logic             busy
);
	// busy while a command waits on a stalled controller
	assign busy = hold & cmd_valid;
	// one take per cycle pair, the queue head updates only after the pop
	always_ff @(posedge clk) begin
		cmd_take <= 1'b0;
		dq_push  <= 1'b0;
		dq_data  <= ~dq_data;
		if (rst) begin
			dq_data <= 32'h0000_0000;
		end else if (cmd_valid && !hold && !cmd_take) begin
			cmd_take <= 1'b1;
			dq_push  <= 1'b1;
			dq_data  <= cmd_data ^ 32'h5a5a_0000;
		end
	end
endmodule : isodio_ctrl_model

// ---- isodio_top_tb.sv ----
// self-checking bench for the isolated digital i/o block
`timescale 1ns/1ps
module isodio_top_tb;
	import isodio_pkg::*;
	logic        SYS_CLK   = 1'b0;
	logic        SYS_RST   = 1'b1;
	logic        HSEL      = 1'b0;
	logic [31:0] HADDR     = 32'h0000_0000;
	logic [1:0]  HTRANS    = 2'h0;
	logic        HWRITE    = 1'b0;
	logic [2:0]  HSIZE     = 3'h2;
	logic [31:0] HWDATA    = 32'h0000_0000;
	logic [7:0]  ISO_IN    = 8'h00;
	logic        hold      = 1'b0;
	logic [31:0] HRDATA;
	logic        HREADYOUT;
	logic        HRESP;
	logic [6:0]  OC_OUT;
	logic        IRQ;
	logic        CMD_VALID;
	logic [31:0] CMD_DATA;
	logic        CMD_TAKE;
	logic        DQ_PUSH;
	logic [31:0] DQ_DATA;
	logic        DQ_FULL;
	logic        CONV_BUSY;
	int          num_errors = 0;
	int          checks     = 0;

	isodio_top dut (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .HSEL(HSEL), .HADDR(HADDR),
		.HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
		.HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
		.ISO_IN(ISO_IN), .OC_OUT(OC_OUT), .IRQ(IRQ), .CMD_VALID(CMD_VALID),
		.CMD_DATA(CMD_DATA), .CMD_TAKE(CMD_TAKE), .DQ_PUSH(DQ_PUSH), .DQ_DATA(DQ_DATA),
		.DQ_FULL(DQ_FULL), .CONV_BUSY(CONV_BUSY));
	isodio_ctrl_model ctrl (.clk(SYS_CLK), .rst(SYS_RST), .hold(hold), .cmd_valid(CMD_VALID),
		.cmd_data(CMD_DATA), .cmd_take(CMD_TAKE), .dq_push(DQ_PUSH), .dq_data(DQ_DATA),
		.busy(CONV_BUSY));

	initial begin
		forever #5 SYS_CLK = ~SYS_CLK;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// single word transfer; waits on hreadyout, no assumed latency
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		HSEL   <= 1'b1;
		HADDR  <= {24'h00_0000, a};
		HTRANS <= HTRANS_NONSEQ;
		HWRITE <= wr;
		do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
		HSEL   <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= wd;
		do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
		rd = HRDATA;
		chk({31'h0, HRESP}, {31'h0, HRESP_OKAY});
	endtask : bus

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask : wr

	task rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		bus(1'b0, a, 32'h0000_0000, r);
		chk(r, exp);
	endtask : rdc

	task t_reset();
		rdc(OFS_POLARITY, 32'h0);
		rdc(OFS_OUTPUT, 32'h0);
		rdc(OFS_LATCH, 32'h0);
		rdc(OFS_IRQ_EN, 32'h0);
		rdc(OFS_CMD_PORT, 32'h5);
		wr(8'h30, 32'hffff_ffff);
		rdc(8'h30, 32'h0);
	endtask : t_reset

	task t_pol_out();
		wr(OFS_POLARITY, 32'h0000_00a5);
		rdc(OFS_POLARITY, 32'h0000_00a5);
		wr(OFS_OUTPUT, 32'hffff_ffff);
		rdc(OFS_OUTPUT, 32'h0000_007f);
		chk({25'h0, OC_OUT}, 32'h7f);
		wr(OFS_OUTPUT, 32'h0000_002a);
		rdc(OFS_OUTPUT, 32'h0000_002a);
		chk({25'h0, OC_OUT}, 32'h2a);
		ISO_IN <= 8'h3c;
		rdc(OFS_RAW_IN, 32'h0000_003c);
	endtask : t_pol_out

	task t_latch();
		wr(OFS_POLARITY, 32'h0000_000f);
		ISO_IN <= 8'h0f;
		wr(OFS_LATCH, 32'h0);
		rdc(OFS_LATCH, 32'h0);
		wr(OFS_IRQ_CLR, 32'h0000_00ff);
		wr(OFS_IRQ_EN, 32'h0000_0001);
		chk({31'h0, IRQ}, 32'h0);
		// channels 0 and 4 reach their active level only briefly
		ISO_IN <= 8'h1e;
		repeat (2) @(posedge SYS_CLK);
		ISO_IN <= 8'h0f;
		rdc(OFS_LATCH, 32'h0000_0011);
		rdc(OFS_LATCH, 32'h0000_0011);
		rdc(OFS_IRQ_STAT, 32'h0000_0011);
		chk({31'h0, IRQ}, 32'h1);
		wr(OFS_LATCH, 32'h0000_00ef);
		rdc(OFS_LATCH, 32'h0000_0001);
		wr(OFS_IRQ_CLR, 32'h0000_0001);
		rdc(OFS_IRQ_STAT, 32'h0000_0010);
		chk({31'h0, IRQ}, 32'h0);
	endtask : t_latch

	task t_queue();
		hold <= 1'b1;
		for (int i = 0; i < QUEUE_DEPTH; i++) wr(OFS_CMD_PORT, 32'h100 + i);
		rdc(OFS_CMD_PORT, 32'hc);
		chk(CMD_DATA, 32'h0000_0100);
		hold <= 1'b0;
		repeat (12) @(posedge SYS_CLK);
		rdc(OFS_CMD_PORT, 32'h3);
		chk({31'h0, DQ_FULL}, 32'h1);
		for (int i = 0; i < QUEUE_DEPTH; i++) rdc(OFS_DATA_PORT, 32'h5a5a_0100 + i);
		rdc(OFS_DATA_PORT, 32'h0);
		rdc(OFS_CMD_PORT, 32'h5);
		wr(OFS_CMD_PORT, 32'h0000_0777);
		repeat (4) @(posedge SYS_CLK);
		hold <= 1'b1;
		wr(OFS_CMD_PORT, 32'h0000_0888);
		wr(OFS_DATA_PORT, 32'h0);
		rdc(OFS_CMD_PORT, 32'h5);
		chk({31'h0, CMD_VALID}, 32'h0);
		chk({31'h0, DQ_FULL}, 32'h0);
		hold <= 1'b0;
	endtask : t_queue

	// reset in mid-run: outputs and settings return to their reset values
	task t_rerun();
		wr(OFS_OUTPUT, 32'h0000_0055);
		SYS_RST <= 1'b1;
		repeat (2) @(posedge SYS_CLK);
		SYS_RST <= 1'b0;
		chk({25'h0, OC_OUT}, 32'h0);
		rdc(OFS_OUTPUT, 32'h0);
		rdc(OFS_POLARITY, 32'h0);
		rdc(OFS_LATCH, 32'h0000_000f);
	endtask : t_rerun

	task print_verdict();
		$display("checks=%0d num_errors=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : print_verdict

	initial begin
		#200us;
		num_errors++;
		print_verdict();
	end

	initial begin
		repeat (4) @(posedge SYS_CLK);
		SYS_RST <= 1'b0;
		t_reset();
		t_pol_out();
		t_latch();
		t_queue();
		t_rerun();
		print_verdict();
	end
endmodule : isodio_top_tb
